// ==== test/scg_periph_model.sv ====
`timescale 1ns/1ps
// Stand-in peripheral: a counter that only advances on its gated clock
module scg_periph_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Gated clock enable from the controller
  input  wire logic       clk_en,
  // Observable state
  output logic      [7:0] count
);
  // State frozen while gated, resumes from the same value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (clk_en) begin
      count <= count + 8'h01;
    end
  end
endmodule

// ==== test/scg_sleep_clock_gating_ctrl_tb.sv ====
`timescale 1ns/1ps
module scg_sleep_clock_gating_ctrl_tb;
  logic       core_clk;
  logic       rst_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       sleep_instr;
  logic       crystal_clk_opt;
  logic       t2_async;
  logic       t2_enabled;
  logic [1:0] t2_mask;
  logic       global_en;
  logic       adc_enabled;
  logic       startup_done;
  logic [6:0] wake;
  logic [1:0] t2_ev;
  logic       cpu_en, flash_en, io_en, adc_en, asy_en, main_en, tosc_en;
  logic       ts2_en, adc_pwr, adc_ext, mux_acc, comp_pwr, ref_en, bod_en;
  logic       irq_go;
  logic       sleeping;
  logic [7:0] pclk_en;
  logic [7:0] preg_en;
  logic [7:0] pcount;
  logic [7:0] rv;
  logic [7:0] frozen;
  int         bad_count;
  int         cmp_count;
  int         waited;

  scg_sleep_clock_gating_ctrl u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .crystal_clk_opt(crystal_clk_opt), .timer2_async_select(t2_async),
    .timer2_enabled(t2_enabled), .timer2_irq_mask(t2_mask),
    .global_irq_en(global_en), .adc_enabled(adc_enabled),
    .comp_uses_ref(1'b1), .comp_enabled(1'b1),
    .brownout_level_fuses(2'b01), .startup_done(startup_done),
    .ext_level_irq(wake[0]), .ext_edge_irq(wake[1]),
    .two_wire_addr_match(wake[2]), .timer2_event(t2_ev),
    .store_ready_irq(wake[3]), .adc_done_irq(wake[4]),
    .watchdog_irq(wake[5]), .other_io_irq(wake[6]),
    .cpu_clk_en(cpu_en), .flash_clk_en(flash_en), .io_clk_en(io_en),
    .adc_clk_en(adc_en), .async_clk_en(asy_en), .main_osc_en(main_en),
    .timer_osc_en(tosc_en), .timer2_sync_clk_en(ts2_en),
    .periph_clk_en(pclk_en), .periph_reg_en(preg_en),
    .adc_power_en(adc_pwr), .adc_extended_conv(adc_ext),
    .comp_mux_access(mux_acc), .comp_power_en(comp_pwr),
    .int_ref_en(ref_en), .brownout_en(bod_en), .cpu_irq_go(irq_go),
    .sleeping(sleeping)
  );

  scg_periph_model u_periph (
    .core_clk(core_clk), .rst_n(rst_n),
    .clk_en(pclk_en[scg_pkg::GATE_TIMER_ZERO]), .count(pcount)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task close_out;
    $display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task pulse_sleep;
    @(posedge core_clk);
    sleep_instr <= 1'b1;
    @(posedge core_clk);
    sleep_instr <= 1'b0;
  endtask

  // Bounded wait on the sleeping flag or on the resume pulse
  task wait_on(input logic go, input logic want);
    int n;
    n = 0;
    while ((go ? irq_go : sleeping) !== want && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({7'h00, go ? irq_go : sleeping}, {7'h00, want});
    waited = n;
  endtask

  task run_mode(input logic [2:0] m, input logic [6:0] src,
                input logic [6:0] ck, input logic [3:0] an);
    wr(scg_pkg::ADDR_CONTROL, {4'h0, m, 1'b1});
    // Standby must resume without waiting for oscillator start-up
    startup_done <= (m != scg_pkg::MODE_STANDBY);
    pulse_sleep();
    wait_on(1'b0, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check({1'b0, cpu_en, flash_en, io_en, adc_en, asy_en, main_en, tosc_en},
          {1'b0, ck});
    check({4'h0, adc_pwr, comp_pwr, ref_en, bod_en}, {4'h0, an});
    @(posedge core_clk);
    wake <= src;
    wait_on(1'b1, 1'b1);
    // Two sync stages, entry, start-up (six in standby), four held
    check(8'(waited),
          (m == scg_pkg::MODE_STANDBY) ? 8'h0D : 8'h08);
    @(posedge core_clk);
    wake <= 7'h00;
    wait_on(1'b0, 1'b0);
    @(posedge core_clk);
    startup_done <= 1'b1;
    rd(scg_pkg::ADDR_STATUS, rv);
    check(rv & 8'h07, {5'h00, m});
    $display("mode %0d done", m);
  endtask

  task t_modes;
    run_mode(scg_pkg::MODE_IDLE, 7'h40, 7'b0011111, 4'hF);
    run_mode(scg_pkg::MODE_ADC_NR, 7'h10, 7'b0001111, 4'hF);
    // Conversion done cleared the flag; an off-on cycle sets it again
    check({7'h00, adc_ext}, 8'h00);
    @(posedge core_clk);
    adc_enabled <= 1'b0;
    @(posedge core_clk);
    adc_enabled <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check({7'h00, adc_ext}, 8'h01);
    run_mode(scg_pkg::MODE_PWR_DN, 7'h04, 7'b0000000, 4'hB);
    run_mode(scg_pkg::MODE_PWR_SV, 7'h20, 7'b0000101, 4'hB);
    run_mode(scg_pkg::MODE_STANDBY, 7'h01, 7'b0000010, 4'hB);
  endtask

  task t_no_arm;
    wr(scg_pkg::ADDR_CONTROL, 8'h00);
    pulse_sleep();
    repeat (6) @(posedge core_clk);
    #1;
    check({7'h00, sleeping}, 8'h00);
    wr(scg_pkg::ADDR_CONTROL, 8'h09);
    pulse_sleep();
    repeat (6) @(posedge core_clk);
    #1;
    check({7'h00, sleeping}, 8'h00);
    @(posedge core_clk);
    crystal_clk_opt <= 1'b0;
    wr(scg_pkg::ADDR_CONTROL, {4'h0, scg_pkg::MODE_STANDBY, 1'b1});
    pulse_sleep();
    repeat (6) @(posedge core_clk);
    #1;
    check({7'h00, sleeping}, 8'h00);
    @(posedge core_clk);
    crystal_clk_opt <= 1'b1;
    $display("no-arm test done");
  endtask

  task t_timer2;
    @(posedge core_clk);
    t2_async <= 1'b0;
    global_en <= 1'b0;
    t2_mask <= 2'b00;
    wr(scg_pkg::ADDR_CONTROL, {4'h0, scg_pkg::MODE_PWR_SV, 1'b1});
    pulse_sleep();
    wait_on(1'b0, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check({2'h0, main_en, tosc_en, ts2_en, io_en, adc_en, cpu_en},
          8'h28);
    @(posedge core_clk);
    t2_ev <= 2'b01;
    wake  <= 7'h0A;
    repeat (10) @(posedge core_clk);
    t2_mask <= 2'b01;
    repeat (10) @(posedge core_clk);
    #1;
    check({7'h00, sleeping}, 8'h01);
    @(posedge core_clk);
    global_en <= 1'b1;
    wait_on(1'b1, 1'b1);
    check(8'(waited), 8'h06);
    @(posedge core_clk);
    t2_ev <= 2'b00;
    wake  <= 7'h00;
    t2_async <= 1'b1;
    wait_on(1'b0, 1'b0);
    $display("timer 2 test done");
  endtask

  task t_gates;
    int n;
    rd(scg_pkg::ADDR_GATES, rv);
    check(rv, scg_pkg::GATES_RESET);
    @(posedge core_clk);
    adc_enabled <= 1'b0; // Converter off before it is gated
    wr(scg_pkg::ADDR_GATES, 8'hFF);
    rd(scg_pkg::ADDR_GATES, rv);
    check(rv, 8'hEF);
    repeat (2) @(posedge core_clk);
    #1;
    frozen = pcount;
    check(pclk_en & 8'hEF, 8'h40);
    check(preg_en & 8'hAF, 8'h00);
    check({7'h00, mux_acc}, 8'h00);
    @(posedge core_clk);
    t2_async <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    check(pclk_en & 8'hEF, 8'h00);
    check(pcount, frozen);
    // Software reinitialises serial units after ungating
    wr(scg_pkg::ADDR_GATES, 8'h00);
    n = 0;
    while (pclk_en[scg_pkg::GATE_TIMER_ZERO] !== 1'b1 && n < 32) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(pcount, frozen);
    check(pclk_en & 8'hEF, 8'hEF);
    check({7'h00, mux_acc}, 8'h01);
    rd(4'hF, rv);
    check(rv, 8'h00);
    @(posedge core_clk);
    t2_async <= 1'b1;
    adc_enabled <= 1'b1;
    $display("gating test done");
  endtask

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_instr = 1'b0;
    crystal_clk_opt = 1'b1;
    t2_async = 1'b1;
    t2_enabled = 1'b1; // Timer 2 kept running, so power-save is apt
    t2_mask = 2'b00;
    global_en = 1'b0;
    adc_enabled = 1'b1;
    startup_done = 1'b1;
    wake = 7'h00;
    t2_ev = 2'b00;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_gates();
    t_no_arm();
    t_modes();
    t_timer2();
    close_out();
  end

  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule

// ==== verilog/scg_pkg.sv ====
package scg_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [3:0] ADDR_GATES   = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;

  // Power-reduction bit positions
  localparam int GATE_CONVERTER     = 0;
  localparam int GATE_ASYNC_SERIAL  = 1;
  localparam int GATE_SERIAL_PERIPH = 2;
  localparam int GATE_RESERVED      = 3 + 1;
  localparam int GATE_TIMER_ONE     = 3;
  localparam int GATE_TIMER_ZERO    = 5;
  localparam int GATE_TIMER_TWO     = 6;
  localparam int GATE_TWO_WIRE      = 7;
  localparam logic [7:0] GATES_RESET = 8'h00;
  localparam logic [7:0] GATES_MASK  = 8'hEF;

  // Control register fields
  localparam int CTL_ARM    = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_MODE_HI = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Sleep mode select encodings
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_ADC_NR  = 3'h1;
  localparam logic [2:0] MODE_PWR_DN  = 3'h2;
  localparam logic [2:0] MODE_PWR_SV  = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;

  // Wake timing in cycles
  localparam logic [3:0] STANDBY_WAKE_CYCLES = 4'h6;
  localparam logic [3:0] IRQ_HOLD_CYCLES     = 4'h4;
  localparam logic [3:0] ZERO_COUNT          = 4'h0;
  localparam logic [3:0] ONE_COUNT           = 4'h1;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b11,
    ST_HOLD  = 2'b10
  } scg_state_type;
endpackage

// ==== verilog/scg_sleep_clock_gating_ctrl.sv ====
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module scg_sleep_clock_gating_ctrl (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // CPU and configuration (same clock)
  input  wire logic       sleep_instr,
  input  wire logic       crystal_clk_opt,
  input  wire logic       timer2_async_select,
  input  wire logic       timer2_enabled,
  input  wire logic [1:0] timer2_irq_mask,
  input  wire logic       global_irq_en,
  input  wire logic       adc_enabled,
  input  wire logic       comp_uses_ref,
  input  wire logic       comp_enabled,
  input  wire logic [1:0] brownout_level_fuses,
  input  wire logic       startup_done,
  // Wake events from pins and async logic
  input  wire logic       ext_level_irq,
  input  wire logic       ext_edge_irq,
  input  wire logic       two_wire_addr_match,
  input  wire logic [1:0] timer2_event,
  input  wire logic       store_ready_irq,
  input  wire logic       adc_done_irq,
  input  wire logic       watchdog_irq,
  input  wire logic       other_io_irq,
  // Clock domain enables
  output logic            cpu_clk_en,
  output logic            flash_clk_en,
  output logic            io_clk_en,
  output logic            adc_clk_en,
  output logic            async_clk_en,
  output logic            main_osc_en,
  output logic            timer_osc_en,
  output logic            timer2_sync_clk_en,
  output logic      [7:0] periph_clk_en,
  output logic      [7:0] periph_reg_en,
  // Analog and status
  output logic            adc_power_en,
  output logic            adc_extended_conv,
  output logic            comp_mux_access,
  output logic            comp_power_en,
  output logic            int_ref_en,
  output logic            brownout_en,
  output logic            cpu_irq_go,
  output logic            sleeping
);

  scg_pkg::scg_state_type state_reg;
  scg_pkg::scg_state_type state_next;
  logic [7:0] gates_reg;
  logic [7:0] control_reg;
  logic [3:0] count_reg;
  logic [2:0] mode_reg;
  logic       irq_wake_reg;
  logic       adc_prev_reg;
  logic       ext_conv_reg;
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;

  logic [2:0] sel;
  logic       sleep_req;
  logic       standby_ok;
  logic       in_sleep;
  logic       m_idle;
  logic       m_anr;
  logic       m_sv;
  logic       m_sb;
  logic       wake;
  logic       gate_active;
  logic [7:0] gates_eff;

  localparam logic [3:0] ONE_C = scg_pkg::ONE_COUNT;

  assign sel = control_reg[scg_pkg::CTL_MODE_HI:scg_pkg::CTL_MODE_LO];
  assign standby_ok = (sel != scg_pkg::MODE_STANDBY) || crystal_clk_opt;
  assign sleep_req = sleep_instr && control_reg[scg_pkg::CTL_ARM]
                     && standby_ok
                     && (sel == scg_pkg::MODE_IDLE
                      || sel == scg_pkg::MODE_ADC_NR
                      || sel == scg_pkg::MODE_PWR_DN
                      || sel == scg_pkg::MODE_PWR_SV
                      || sel == scg_pkg::MODE_STANDBY);
  assign in_sleep = (state_reg == scg_pkg::ST_SLEEP);
  assign m_idle = in_sleep && mode_reg == scg_pkg::MODE_IDLE;
  assign m_anr  = in_sleep && mode_reg == scg_pkg::MODE_ADC_NR;
  assign m_sv   = in_sleep && mode_reg == scg_pkg::MODE_PWR_SV;
  assign m_sb   = in_sleep && mode_reg == scg_pkg::MODE_STANDBY;

  // Synchronised wake sources
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {other_io_irq, watchdog_irq, adc_done_irq,
                    store_ready_irq, timer2_event, two_wire_addr_match,
                    ext_edge_irq, ext_level_irq};
      sync2_reg <= sync1_reg;
    end
  end

  // Wake qualification per mode
  always_comb begin
    wake = sync2_reg[0] || sync2_reg[2] || sync2_reg[7];
    if (m_idle) begin
      wake = wake || sync2_reg[1] || sync2_reg[8];
    end
    if (m_idle || m_anr) begin
      wake = wake || sync2_reg[5] || sync2_reg[6];
    end
    if (m_idle || m_anr || m_sv) begin
      wake = wake || (global_irq_en
             && |(sync2_reg[4:3] & timer2_irq_mask));
    end
  end

  // Sleep state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      scg_pkg::ST_RUN:
        if (sleep_req) state_next = scg_pkg::ST_SLEEP;
      scg_pkg::ST_SLEEP:
        if (wake) state_next = scg_pkg::ST_START;
      scg_pkg::ST_START:
        if ((mode_reg == scg_pkg::MODE_STANDBY) ? (count_reg == ONE_C)
            : startup_done) state_next = scg_pkg::ST_HOLD;
      scg_pkg::ST_HOLD:
        if (count_reg == ONE_C) state_next = scg_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= scg_pkg::ST_RUN;
      mode_reg <= scg_pkg::MODE_IDLE;
      irq_wake_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == scg_pkg::ST_RUN && sleep_req) begin
        mode_reg <= sel;
      end
      if (state_reg == scg_pkg::ST_SLEEP && wake) begin
        irq_wake_reg <= 1'b1;
      end else if (state_reg == scg_pkg::ST_RUN) begin
        irq_wake_reg <= 1'b0;
      end
    end
  end

  // Wake delay counter: standby six, then hold four
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= scg_pkg::ZERO_COUNT;
    end else if (state_reg == scg_pkg::ST_SLEEP && wake) begin
      count_reg <= scg_pkg::STANDBY_WAKE_CYCLES;
    end else if (state_reg == scg_pkg::ST_START && state_next
                 == scg_pkg::ST_HOLD) begin
      count_reg <= scg_pkg::IRQ_HOLD_CYCLES;
    end else if (count_reg != scg_pkg::ZERO_COUNT) begin
      count_reg <= count_reg - ONE_C;
    end
  end

  // Register file
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gates_reg <= scg_pkg::GATES_RESET;
      control_reg <= scg_pkg::CONTROL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == scg_pkg::ADDR_GATES) begin
        gates_reg <= reg_wdata & scg_pkg::GATES_MASK;
      end
      if (reg_addr == scg_pkg::ADDR_CONTROL) begin
        control_reg <= {4'h0, reg_wdata[3:0]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        scg_pkg::ADDR_GATES:   reg_rdata <= gates_reg;
        scg_pkg::ADDR_CONTROL: reg_rdata <= control_reg;
        scg_pkg::ADDR_STATUS:  reg_rdata <= {5'h00, mode_reg};
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Clock gates apply only in active and idle, register gates always; timer 2 gate only when synchronous
  assign gate_active = (state_reg != scg_pkg::ST_SLEEP) || m_idle;
  always_comb begin
    gates_eff = gates_reg;
    gates_eff[scg_pkg::GATE_TIMER_TWO] = gates_reg[scg_pkg::GATE_TIMER_TWO]
                                        && !timer2_async_select;
  end

  // Registered clock enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
      flash_clk_en <= 1'b1;
      io_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      async_clk_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b0;
      timer2_sync_clk_en <= 1'b1;
      periph_clk_en <= 8'hFF;
      periph_reg_en <= 8'hFF;
    end else begin
      cpu_clk_en <= !in_sleep;
      flash_clk_en <= !in_sleep;
      io_clk_en <= !in_sleep || m_idle;
      adc_clk_en <= !in_sleep || m_idle || m_anr;
      async_clk_en <= !in_sleep || m_idle || m_anr || m_sv;
      main_osc_en <= !in_sleep || m_idle || m_anr || m_sb
                     || (m_sv && !timer2_async_select);
      timer_osc_en <= timer2_async_select
                      && (!in_sleep || m_idle || m_anr || m_sv);
      timer2_sync_clk_en <= !timer2_async_select && timer2_enabled
                            && (!in_sleep || m_idle || m_sv)
                            && !gates_eff[scg_pkg::GATE_TIMER_TWO];
      periph_clk_en <= ~(gate_active ? gates_eff : 8'h00)
                       & {8{!in_sleep || m_idle}};
      periph_reg_en <= ~gates_eff;
    end
  end

  // Analog and always-on blocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_power_en <= 1'b0;
      adc_prev_reg <= 1'b0;
      ext_conv_reg <= 1'b0;
      adc_extended_conv <= 1'b0;
      comp_mux_access <= 1'b1;
      comp_power_en <= 1'b0;
      int_ref_en <= 1'b0;
      brownout_en <= 1'b0;
      cpu_irq_go <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      adc_power_en <= adc_enabled;
      adc_prev_reg <= adc_enabled;
      if (adc_enabled && !adc_prev_reg) begin
        ext_conv_reg <= 1'b1;
      end else if (sync2_reg[6]) begin
        // Cleared by the synchronised conversion-done pulse
        ext_conv_reg <= 1'b0;
      end
      adc_extended_conv <= ext_conv_reg;
      comp_mux_access <= !gates_reg[scg_pkg::GATE_CONVERTER];
      comp_power_en <= comp_enabled
                       && (!in_sleep || m_idle || m_anr);
      int_ref_en <= (comp_enabled && comp_uses_ref) || adc_enabled;
      brownout_en <= |brownout_level_fuses;
      cpu_irq_go <= state_reg == scg_pkg::ST_HOLD && state_next
                    == scg_pkg::ST_RUN && irq_wake_reg;
      sleeping <= in_sleep;
    end
  end

  chk_idle_cpu_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    m_idle |=> !cpu_clk_en && io_clk_en)
    else $error("idle clocks wrong");
  chk_pdown_all_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    in_sleep && mode_reg == scg_pkg::MODE_PWR_DN |=> !main_osc_en
    && !async_clk_en && !adc_clk_en)
    else $error("power-down clock left running");
  chk_sleep_armed: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(in_sleep) |-> $past(control_reg[scg_pkg::CTL_ARM]))
    else $error("sleep without arm bit");
  chk_standby_six: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    m_sb && wake |=> (state_reg == scg_pkg::ST_START) [*6])
    else $error("standby wake not six cycles");
  chk_hold_four: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state_reg == scg_pkg::ST_HOLD) |-> 
    (state_reg == scg_pkg::ST_HOLD) [*4]
    ##1 (state_reg == scg_pkg::ST_RUN))
    else $error("interrupt hold not four cycles");
  chk_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !gates_reg[scg_pkg::GATE_RESERVED])
    else $error("reserved gate bit set");
  chk_t2_async: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    timer2_async_select |=> !timer2_sync_clk_en)
    else $error("sync timer clock in async mode");
  chk_save_osc: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    m_sv && !timer2_async_select |=> !timer_osc_en && !io_clk_en)
    else $error("power-save oscillator wrong");
  chk_comp_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    in_sleep && !m_idle && !m_anr |=> !comp_power_en)
    else $error("comparator left on");
  chk_gate_clk: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !in_sleep && gates_reg[scg_pkg::GATE_TWO_WIRE]
    |=> !periph_clk_en[scg_pkg::GATE_TWO_WIRE])
    else $error("gated clock still running");
  chk_t2_sync_only: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    m_sv |=> !cpu_clk_en && !io_clk_en && !adc_clk_en)
    else $error("sync clock reached other domains");
  chk_standby_osc: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    m_sb |=> main_osc_en && !async_clk_en && !timer_osc_en)
    else $error("standby oscillator wrong");
  chk_idle_tosc: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (m_idle || m_anr) && !timer2_async_select |=> !timer_osc_en)
    else $error("timer oscillator on for sync timer");
  chk_reg_blocked: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    gates_reg[scg_pkg::GATE_SERIAL_PERIPH]
    |=> !periph_reg_en[scg_pkg::GATE_SERIAL_PERIPH])
    else $error("gated registers still open");
  chk_mux_blocked: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    gates_reg[scg_pkg::GATE_CONVERTER] |=> !comp_mux_access)
    else $error("comparator kept converter mux");
  chk_sleep_gates: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    in_sleep && !m_idle |=> periph_clk_en == 8'h00)
    else $error("peripheral clock running in deep sleep");
  chk_adc_kept: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    adc_enabled |=> adc_power_en)
    else $error("converter dropped in sleep");
  chk_bod_kept: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    |brownout_level_fuses |=> brownout_en)
    else $error("brown-out detector dropped");

  cov_save: cover property (@(posedge core_clk) disable iff (!rst_n)
    m_sv ##1 state_reg == scg_pkg::ST_START);
  cov_standby: cover property (@(posedge core_clk) disable iff (!rst_n)
    m_sb ##1 !in_sleep);
  cov_idle_gate: cover property (@(posedge core_clk) disable iff (!rst_n)
    m_idle && gates_reg != 8'h00);
  cov_irq_go: cover property (@(posedge core_clk) disable iff (!rst_n)
    cpu_irq_go);

endmodule
